// File: bench/dsdma_asserts.sv
// assertion checker for the dual sub-block dma top
`timescale 1ns/1ps
`default_nettype none
module dsdma_asserts (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic wb_ack_o,
  input wire logic [2:0] mst_req_o,
  input wire logic [2:0] mst_we_o,
  input wire logic [5:0] mst_size_o,
  input wire logic [95:0] mst_addr_o,
  input wire logic [95:0] mst_wdata_o,
  input wire logic [2:0] mst_ack_i,
  input wire logic [15:0] srq_o,
  input wire logic [3:0] link_srq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_loc;
    wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i[31:30] != 2'b11;
  endsequence
  sequence s_one_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  AST_LOCAL_ACK: assert property (s_loc |=> s_one_ack)
    else $error("local access not acked once");
  AST_REQ_HOLD: assert property (mst_req_o[1] && !mst_ack_i[1] |=> mst_req_o[1] && $stable(mst_addr_o[63:32]))
    else $error("pending move not held");
  AST_REQ_DROP: assert property (mst_req_o[0] && mst_ack_i[0] |=> !mst_req_o[0])
    else $error("request kept after ack");
  AST_REMOTE_ONLY: assert property (mst_req_o[1] |-> mst_addr_o[63:62] == 2'b11)
    else $error("remote bus used off region");
  AST_LINK_ONLY: assert property (mst_req_o[2] |-> mst_addr_o[95:94] == 2'b10 && mst_addr_o[95:64] != 32'h8000_0000)
    else $error("link bus request misrouted");
  AST_SIZE_LEGAL: assert property (mst_req_o[0] |-> mst_size_o[1:0] != 2'b11)
    else $error("illegal move width");
  AST_BYTE_LANES: assert property (mst_req_o[0] && mst_we_o[0] && mst_size_o[1:0] == 2'b00 |-> mst_wdata_o[31:8] == 24'h00_0000)
    else $error("byte write uses upper lanes");
  AST_SRQ_PULSE: assert property (srq_o[0] |=> !srq_o[0])
    else $error("channel request not a pulse");
  AST_LINK_PULSE: assert property (link_srq_o[0] |=> !link_srq_o[0])
    else $error("link request not a pulse");
endmodule // dsdma_asserts
bind dsdma_top dsdma_asserts u_asserts (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .mst_req_o(mst_req_o), .mst_we_o(mst_we_o),
  .mst_size_o(mst_size_o), .mst_addr_o(mst_addr_o), .mst_wdata_o(mst_wdata_o), .mst_ack_i(mst_ack_i),
  .srq_o(srq_o), .link_srq_o(link_srq_o));
`default_nettype wire

// File: bench/dsdma_slave_model.sv
// bus slave model answering the three master interfaces
`timescale 1ns/1ps
`default_nettype none
module dsdma_slave_model (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [2:0] req_i,
  input wire logic [95:0] addr_i,
  output var logic [2:0] ack_o,
  output var logic [95:0] rdata_o
);
  logic [2:0] slow;
  logic [2:0] cnt [0:2];
  logic [31:0] tick;
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack_o <= 3'b000;
      slow <= 3'b000;
      tick <= 32'h0000_0000;
      rdata_o <= 96'h0;
      for (int i = 0; i < 3; i++) cnt[i] <= 3'd0;
    end else begin
      tick <= tick + 32'h0000_0001;
      for (int i = 0; i < 3; i++) begin
        ack_o[i] <= 1'b0;
        // idle data keeps changing so stale values never match
        rdata_o[32*i +: 32] <= tick;
        if (req_i[i] && !ack_o[i]) begin
          if (cnt[i] == 3'd0) begin
            ack_o[i] <= 1'b1;
            rdata_o[32*i +: 32] <= ~addr_i[32*i +: 32];
            cnt[i] <= slow[i] ? 3'd3 : 3'd0;
            slow[i] <= ~slow[i];
          end else begin
            cnt[i] <= cnt[i] - 3'd1;
          end
        end
      end
    end
  end
endmodule // dsdma_slave_model
`default_nettype wire

// File: bench/tb_top.sv
// self-checking bench for the dual sub-block dma top
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [31:0] wb_adr_i = 32'h0000_0000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o;
  logic [15:0] hw_req_i = 16'h0000;
  logic [3:0] link_evt_i = 4'h0;
  logic [2:0] mst_req_o, mst_we_o, mst_ack_i;
  logic [5:0] mst_size_o;
  logic [95:0] mst_addr_o, mst_wdata_o, mst_rdata_i;
  logic [15:0] srq_o;
  logic [3:0] link_srq_o;
  logic [31:0] wq[$];
  logic [31:0] wd[$];
  int failures = 0;
  int check_count = 0;
  int srq_cnt = 0;
  int lsrq_cnt = 0;
  always #5 clock_i = ~clock_i;
  dsdma_top DUT (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .hw_req_i(hw_req_i), .link_evt_i(link_evt_i), .mst_req_o(mst_req_o),
    .mst_we_o(mst_we_o), .mst_size_o(mst_size_o), .mst_addr_o(mst_addr_o), .mst_wdata_o(mst_wdata_o),
    .mst_ack_i(mst_ack_i), .mst_rdata_i(mst_rdata_i), .srq_o(srq_o), .link_srq_o(link_srq_o));
  dsdma_slave_model u_slave (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .req_i(mst_req_o),
    .addr_i(mst_addr_o), .ack_o(mst_ack_i), .rdata_o(mst_rdata_i));
  always @(posedge clock_i) begin
    if (srq_o[0] === 1'b1) srq_cnt++;
    if (link_srq_o[0] === 1'b1) lsrq_cnt++;
    if (mst_req_o[0] & mst_ack_i[0] & mst_we_o[0]) begin
      wq.push_back(mst_addr_o[31:0]);
      wd.push_back(mst_wdata_o[31:0]);
    end
  end
  ////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (failures == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb_cyc(input logic we, input logic [31:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clock_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    wb_cyc(1'b1, a, d);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    wb_cyc(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask
  task automatic wait_wq(input int n);
    for (int i = 0; i < 300 && wq.size() < n; i++) @(posedge clock_i);
    if (wq.size() < n) failures++;
  endtask
  task automatic wait_done(input int b);
    for (int i = 0; i < 40; i++) begin
      wb_cyc(1'b0, 32'h0000_0110, 32'h0000_0000);
      if (rd[b] === 1'b1) break;
    end
    if (rd[b] !== 1'b1) failures++;
  endtask
  // msb first, no reflection, no final inversion
  function automatic logic [31:0] crc(input logic [31:0] c, input logic [31:0] d, input int bits);
    for (int i = bits - 1; i >= 0; i--) c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? 32'h04C1_1DB7 : 32'h0);
    return c;
  endfunction
  ////////////////////////////////////////////////////////
  initial begin
    #100us;
    failures++;
    give_verdict;
  end
  initial begin
    repeat (10) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    @(posedge clock_i);
    wr(32'h0000_0000, 32'hFEDC_BA98);
    rdc(32'h0000_0000, 32'hFEDC_BA98);
    rdc(32'h0000_0114, 32'h0000_0000);
    wr(32'h0000_0108, 32'h1234_5678);
    wr(32'h0000_0104, 32'h0000_0001);
    wr(32'h0000_0104, 32'hCAFE_F00D);
    rdc(32'h0000_0108, crc(crc(32'h1234_5678, 32'h1, 32), 32'hCAFE_F00D, 32));
    rdc(32'h0000_0104, 32'h0000_0000);
    // channel 0: two word moves, single mode, one per software request
    wr(32'h0000_0000, 32'h0000_1000);
    wr(32'h0000_0004, 32'h0000_2000);
    wr(32'h0000_000C, 32'h0000_0002);
    wr(32'h0000_0008, 32'h8008_0B01);
    wait_wq(1);
    wr(32'h0000_0008, 32'h8008_0B01);
    wait_wq(2);
    chk(wq[1], 32'h0000_2004);
    chk(wd[1], ~32'h0000_1004);
    wait_done(0);
    rdc(32'h0000_0008, 32'h0108_0B00);
    rdc(32'h0000_000C, 32'h0000_0000);
    rdc(32'h0000_0000, 32'h0000_1008);
    chk(srq_cnt, 1);
    // channel 1: byte read fed to the checker input
    wr(32'h0000_0108, 32'h0000_0000);
    wr(32'h0000_0010, 32'h0000_3001);
    wr(32'h0000_0014, 32'h8000_0000);
    wr(32'h0000_001C, 32'h0000_0001);
    wr(32'h0000_0018, 32'h8000_0201);
    wait_done(1);
    rdc(32'h0000_0108, crc(32'h0, ~32'h0000_3001, 8));
    // channel 4: half word, decrementing source
    wr(32'h0000_0040, 32'h0000_5002);
    wr(32'h0000_0044, 32'h0000_6000);
    wr(32'h0000_004C, 32'h0000_0001);
    wr(32'h0000_0048, 32'h8000_0C81);
    wait_done(4);
    rdc(32'h0000_0040, 32'h0000_5000);
    chk(wd[2], 32'h0000_AFFD);
    // channels 2 and 3 on hardware lines 0 and 5 together, 3 high priority
    wr(32'h0000_0020, 32'h0000_7000);
    wr(32'h0000_0024, 32'h0000_7100);
    wr(32'h0000_002C, 32'h0000_0001);
    wr(32'h0000_0028, 32'h0000_0B05);
    wr(32'h0000_0030, 32'h0000_7200);
    wr(32'h0000_0034, 32'h0000_7300);
    wr(32'h0000_003C, 32'h0000_0001);
    wr(32'h0000_0038, 32'h0000_0B5F);
    hw_req_i <= 16'h0021;
    wait_wq(5);
    hw_req_i <= 16'h0000;
    chk(wq[3], 32'h0000_7300);
    chk(wq[4], 32'h0000_7100);
    wait_done(3);
    rdc(32'h0000_0038, 32'h0100_0B5F);
    rdc(32'h0000_003C, 32'h0000_0001);
    // channel 5: circular source inside 16 bytes, destination on the link bus
    wr(32'h0000_0050, 32'h0000_900C);
    wr(32'h0000_0054, 32'h8000_0100);
    wr(32'h0000_005C, 32'h0000_0001);
    wr(32'h0000_0058, 32'h8002_8B01);
    wait_done(5);
    rdc(32'h0000_0050, 32'h0000_9000);
    rdc(32'h0000_0054, 32'h8000_0104);
    // channels 6, 7 and 8 start together; sub-block 1 has the buses first
    wr(32'h0000_0100, 32'h0000_0001);
    for (int n = 6; n < 9; n++) begin
      wr(n * 16, 32'h0000_A000 + n * 256);
      wr(n * 16 + 4, 32'h0000_B000 + n * 256);
      wr(n * 16 + 12, 32'h0000_0001);
      wr(n * 16 + 8, 32'h0000_0B35);
    end
    hw_req_i <= 16'h0808;
    wait_wq(8);
    hw_req_i <= 16'h0000;
    chk(wq[5], 32'h0000_B800);
    chk(wq[6], 32'h0000_B600);
    chk(wq[7], 32'h0000_B700);
    rdc(32'hC000_0010, ~32'hC000_0010);
    wr(32'h0000_010C, 32'h0000_0001);
    link_evt_i <= 4'h1;
    repeat (8) @(posedge clock_i);
    link_evt_i <= 4'h0;
    repeat (4) @(posedge clock_i);
    chk(lsrq_cnt, 1);
    give_verdict;
  end
endmodule // tb_top
`default_nettype wire

// File: rtl/dsdma_defs.vh
// constants for the dual sub-block dma controller with checksum checker
`ifndef DSDMA_DEFS_VH
`define DSDMA_DEFS_VH
// channel register index inside a channel group (byte address = ch*16 + idx*4)
`define DSD_R_SRC 2'd0
`define DSD_R_DST 2'd1
`define DSD_R_CTL 2'd2
`define DSD_R_CNT 2'd3
// global register index (byte address = 0x100 + idx*4)
`define DSD_G_SUBPRIO 3'd0
`define DSD_G_CHKIN 3'd1
`define DSD_G_CHKRES 3'd2
`define DSD_G_LINKEN 3'd3
`define DSD_G_DONE 3'd4
`define DSD_GLOBAL_BIT 8
// control and status fields
`define DSD_C_EN 0
`define DSD_C_CONT 1
`define DSD_C_HWEN 2
`define DSD_C_PRIO 3
`define DSD_C_SEL 6:4
`define DSD_C_WID 8:7
`define DSD_C_SMOD 10:9
`define DSD_C_DMOD 12:11
`define DSD_C_CSZ 16:13
`define DSD_C_CSRC 17
`define DSD_C_CDST 18
`define DSD_C_IRQEN 19
`define DSD_C_DONE 24
`define DSD_C_SWREQ 31
`define DSD_C_WMASK 32'h000F_FFFF
`define DSD_C_DONEM 32'h0100_0000
// reset values
`define DSD_CTL_RST 32'h0000_0000
`define DSD_ADDR_RST 32'h0000_0000
`define DSD_CNT_RST 16'h0000
`define DSD_CRC_RST 32'h0000_0000
// checksum generator and checker input address on the link interface
`define DSD_POLY 32'h04C1_1DB7
`define DSD_CHK_ADDR 32'h8000_0000
// address regions and bus interfaces
`define DSD_RG_RPB 2'b11
`define DSD_RG_LNK 2'b10
`define DSD_IF_SPB 2'd0
`define DSD_IF_RPB 2'd1
`define DSD_IF_LNK 2'd2
`define DSD_OWN_BRG 2'd2
`define DSD_SZ_WORD 2'd2
`endif

// File: rtl/dsdma_top.v
// dual sub-block dma controller, bus switch, remote bridge and checksum checker
//
// Overview of operation
// - sixteen channels in two independent sub-blocks of eight, one move each
// - each channel picks its hardware request from eight sub-block inputs
// - two-level channel priority arbitrates competing channels of one sub-block
// - transfer starts on software request bit or hardware request edge
// - bus switch grants each interface by programmable sub-block priority
// - each bus interface holds one buffered pending move
// - single mode clears channel enable after last transfer
// - continuous mode keeps enable and reloads the transfer count
// - 32-bit source and destination addresses updated after each move
// - circular option wraps address inside a power-of-two buffer
// - transfer width per channel is 8, 16 or 32 bits
// - per channel: source, destination, control/status, count registers
// - switch serves system bus, remote bus and link/checker interface
// - wishbone accesses to remote region bridged; controller sole remote master
// - channel and link service requests generated here
// - checker input written by any master or by channel moves
// - each checker input write updates the result register once
// - checksum generator is the 32-bit polynomial, non-ethernet algorithm
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`include "dsdma_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module dsdma_top (
  input wire clock_i,
  input wire sys_rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [31:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [15:0] hw_req_i,
  input wire [3:0] link_evt_i,
  output reg [2:0] mst_req_o,
  output reg [2:0] mst_we_o,
  output reg [5:0] mst_size_o,
  output reg [95:0] mst_addr_o,
  output reg [95:0] mst_wdata_o,
  input wire [2:0] mst_ack_i,
  input wire [95:0] mst_rdata_i,
  output reg [15:0] srq_o,
  output reg [3:0] link_srq_o
);

localparam [3:0] S_IDLE = 4'b0001;
localparam [3:0] S_RD = 4'b0010;
localparam [3:0] S_WR = 4'b0100;
localparam [3:0] S_UPD = 4'b1000;

reg [31:0] src [0:15];
reg [31:0] dst [0:15];
reg [31:0] ctl [0:15];
reg [15:0] cnt [0:15];
reg [15:0] cini [0:15];
reg [15:0] swp;
reg [15:0] hwp;
reg [15:0] rq1;
reg [15:0] rq2;
reg [15:0] rq3;
reg [3:0] le1;
reg [3:0] le2;
reg [3:0] le3;
reg subprio;
reg [31:0] chk;
reg [3:0] linken;
reg [3:0] st [0:1];
reg [2:0] cur [0:1];
reg [31:0] dat [0:1];
reg [1:0] iss;
reg biss;
reg [1:0] bown [0:2];
reg [1:0] rqv;
reg [1:0] rqwe;
reg [1:0] rqchk;
reg [1:0] tk;
reg [1:0] rv;
reg [1:0] anyr;
reg tkb;
reg used;
reg [31:0] rqa [0:1];
reg [1:0] rqif [0:1];
reg [1:0] rqsz [0:1];
reg [31:0] rdd [0:1];
reg [2:0] pk [0:1];
reg [31:0] rdm;
wire [15:0] rdy;
wire [15:0] doneb;
wire [15:0] hedge;
wire [3:0] wc;
wire wb_rem;
wire wb_loc;
wire brq;
wire chk_wb;
wire [15:0] cnt_lanes;
integer c;
integer s;
integer i;
integer ci;
integer si;
integer ii;
integer j;
integer k;

assign wc = wb_adr_i[7:4];
assign cnt_lanes = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
assign wb_rem = (wb_adr_i[31:30] == `DSD_RG_RPB);
assign wb_loc = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_rem;
assign brq = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_rem & ~biss;
assign chk_wb = wb_loc & wb_we_i & wb_adr_i[`DSD_GLOBAL_BIT] &
  ((wb_adr_i[4:2] == `DSD_G_CHKIN) | (wb_adr_i[4:2] == `DSD_G_CHKRES));

////////////////////////////////////////////////////////////////////////
// helpers

function [31:0] wmrg;
  input [31:0] o;
  reg [31:0] m;
  begin
    m = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wmrg = (o & ~m) | (wb_dat_i & m);
  end
endfunction

function [31:0] wmsk;
  input [1:0] w;
  begin
    if (w == 2'd0) wmsk = 32'h0000_00FF;
    else if (w == 2'd1) wmsk = 32'h0000_FFFF;
    else wmsk = 32'hFFFF_FFFF;
  end
endfunction

function [1:0] regif;
  input [31:0] a;
  begin
    if (a[31:30] == `DSD_RG_RPB) regif = `DSD_IF_RPB;
    else if (a[31:30] == `DSD_RG_LNK) regif = `DSD_IF_LNK;
    else regif = `DSD_IF_SPB;
  end
endfunction

function [31:0] amod;
  input [31:0] a;
  input [1:0] m;
  input [1:0] w;
  input cen;
  input [3:0] cz;
  reg [31:0] n;
  reg [31:0] q;
  begin
    if (m == 2'd1) n = a + (32'h0000_0001 << w);
    else if (m == 2'd2) n = a - (32'h0000_0001 << w);
    else n = a;
    q = (32'h0000_0001 << cz) - 32'h0000_0001;
    if (cen && (cz != 4'd0)) n = (a & ~q) | (n & q);
    amod = n;
  end
endfunction

// one bit per loop step, all steps unrolled into one clock; a 32-bit word costs no extra cycles
function [31:0] crc;
  input [31:0] cv;
  input [31:0] d;
  input [1:0] w;
  integer n;
  reg [31:0] r;
  reg b;
  begin
    r = cv;
    for (n = 31; n >= 0; n = n - 1) begin
      if (n < (8 << w)) begin
        b = r[31] ^ d[n];
        r = {r[30:0], 1'b0} ^ ({32{b}} & `DSD_POLY);
      end
    end
    crc = r;
  end
endfunction

////////////////////////////////////////////////////////////////////////
// per-channel status

genvar g;
generate
  for (g = 0; g < 16; g = g + 1) begin : g_ch
    assign doneb[g] = ctl[g][`DSD_C_DONE];
    assign rdy[g] = ctl[g][`DSD_C_EN] & (|cnt[g]) & (swp[g] | hwp[g]);
    assign hedge[g] = ctl[g][`DSD_C_HWEN] & rq2[(g / 8) * 8 + ctl[g][`DSD_C_SEL]] &
      ~rq3[(g / 8) * 8 + ctl[g][`DSD_C_SEL]];
  end
endgenerate

////////////////////////////////////////////////////////////////////////
// register read mux

always @* begin
  rdm = 32'h0000_0000;
  if (!wb_adr_i[`DSD_GLOBAL_BIT]) begin
    case (wb_adr_i[3:2])
      `DSD_R_SRC: rdm = src[wc];
      `DSD_R_DST: rdm = dst[wc];
      `DSD_R_CTL: rdm = {swp[wc], ctl[wc][30:0]};
      default: rdm = {16'h0000, cnt[wc]};
    endcase
  end else begin
    case (wb_adr_i[4:2])
      `DSD_G_SUBPRIO: rdm = {31'h0000_0000, subprio};
      `DSD_G_CHKRES: rdm = chk;
      `DSD_G_LINKEN: rdm = {28'h000_0000, linken};
      `DSD_G_DONE: rdm = {16'h0000, doneb};
      default: rdm = 32'h0000_0000;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////
// engine requests, channel pick and bus switch

always @* begin
  tk = 2'b00;
  tkb = 1'b0;
  used = 1'b0;
  rv = 2'b00;
  anyr = 2'b00;
  for (si = 0; si < 2; si = si + 1) begin
    ci = si * 8 + cur[si];
    rqv[si] = ((st[si] == S_RD) & ~iss[si]) | (st[si] == S_WR);
    rqwe[si] = (st[si] == S_WR);
    rqa[si] = rqwe[si] ? dst[ci] : src[ci];
    rqsz[si] = ctl[ci][`DSD_C_WID];
    rqif[si] = regif(rqa[si]);
    rqchk[si] = rqwe[si] & (rqa[si] == `DSD_CHK_ADDR);
    pk[si] = 3'd0;
    for (j = 7; j >= 0; j = j - 1) begin
      if (rdy[si * 8 + j] & ~ctl[si * 8 + j][`DSD_C_PRIO]) begin
        anyr[si] = 1'b1;
        pk[si] = j[2:0];
      end
    end
    for (j = 7; j >= 0; j = j - 1) begin
      if (rdy[si * 8 + j] & ctl[si * 8 + j][`DSD_C_PRIO]) begin
        anyr[si] = 1'b1;
        pk[si] = j[2:0];
      end
    end
    rdd[si] = 32'h0000_0000;
    for (ii = 0; ii < 3; ii = ii + 1) begin
      if (mst_req_o[ii] & mst_ack_i[ii] & ~mst_we_o[ii] & (bown[ii] == {1'b0, si[0]})) begin
        rv[si] = 1'b1;
        rdd[si] = mst_rdata_i[ii * 32 +: 32];
      end
    end
  end
  for (ii = 0; ii < 3; ii = ii + 1) begin
    used = 1'b0;
    // the bridge goes first so a waiting system master is never starved
    if ((ii == 1) && brq && !mst_req_o[1]) begin
      tkb = 1'b1;
      used = 1'b1;
    end
    for (k = 0; k < 2; k = k + 1) begin
      si = subprio ? 1 - k : k;
      if (!used && rqv[si] && (rqif[si] == ii[1:0]) && (rqchk[si] ? !chk_wb : !mst_req_o[ii])) begin
        tk[si] = 1'b1;
        used = 1'b1;
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////
// state

always @(posedge clock_i or posedge sys_rst_i) begin
  if (sys_rst_i) begin
    for (c = 0; c < 16; c = c + 1) begin
      src[c] <= `DSD_ADDR_RST;
      dst[c] <= `DSD_ADDR_RST;
      ctl[c] <= `DSD_CTL_RST;
      cnt[c] <= `DSD_CNT_RST;
      cini[c] <= `DSD_CNT_RST;
    end
    for (s = 0; s < 2; s = s + 1) begin
      st[s] <= S_IDLE;
      cur[s] <= 3'd0;
      dat[s] <= 32'h0000_0000;
    end
    for (i = 0; i < 3; i = i + 1) bown[i] <= 2'd0;
    swp <= 16'h0000;
    hwp <= 16'h0000;
    rq1 <= 16'h0000;
    rq2 <= 16'h0000;
    rq3 <= 16'h0000;
    le1 <= 4'h0;
    le2 <= 4'h0;
    le3 <= 4'h0;
    subprio <= 1'b0;
    chk <= `DSD_CRC_RST;
    linken <= 4'h0;
    iss <= 2'b00;
    biss <= 1'b0;
    wb_dat_o <= 32'h0000_0000;
    wb_ack_o <= 1'b0;
    mst_req_o <= 3'b000;
    mst_we_o <= 3'b000;
    mst_size_o <= 6'h00;
    mst_addr_o <= {96{1'b0}};
    mst_wdata_o <= {96{1'b0}};
    srq_o <= 16'h0000;
    link_srq_o <= 4'h0;
  end else begin
    rq1 <= hw_req_i;
    rq2 <= rq1;
    rq3 <= rq2;
    le1 <= link_evt_i;
    le2 <= le1;
    le3 <= le2;
    srq_o <= 16'h0000;
    link_srq_o <= le2 & ~le3 & linken;
    wb_ack_o <= 1'b0;
    if (wb_loc) begin
      wb_ack_o <= 1'b1;
      wb_dat_o <= rdm;
      if (wb_we_i && !wb_adr_i[`DSD_GLOBAL_BIT]) begin
        case (wb_adr_i[3:2])
          `DSD_R_SRC: src[wc] <= wmrg(src[wc]);
          `DSD_R_DST: dst[wc] <= wmrg(dst[wc]);
          `DSD_R_CTL: ctl[wc] <= (wmrg(ctl[wc]) & `DSD_C_WMASK) |
            (ctl[wc] & `DSD_C_DONEM & ~({32{wb_sel_i[3]}} & wb_dat_i & `DSD_C_DONEM));
          default: begin
            cnt[wc] <= (cnt[wc] & ~cnt_lanes) | (wb_dat_i[15:0] & cnt_lanes);
            cini[wc] <= (cnt[wc] & ~cnt_lanes) | (wb_dat_i[15:0] & cnt_lanes);
          end
        endcase
      end
      if (wb_we_i && wb_adr_i[`DSD_GLOBAL_BIT]) begin
        case (wb_adr_i[4:2])
          `DSD_G_SUBPRIO: subprio <= wb_dat_i[0];
          `DSD_G_CHKIN: chk <= crc(chk, wb_dat_i, `DSD_SZ_WORD);
          `DSD_G_CHKRES: chk <= wmrg(chk);
          `DSD_G_LINKEN: linken <= wb_dat_i[3:0];
          default: ;
        endcase
      end
    end
    if (tkb) biss <= 1'b1;
    if (mst_req_o[1] & mst_ack_i[1] & (bown[1] == `DSD_OWN_BRG)) begin
      wb_ack_o <= 1'b1;
      wb_dat_o <= mst_rdata_i[63:32];
      biss <= 1'b0;
    end
    // one entry per interface; it stands until the slave acks
    for (i = 0; i < 3; i = i + 1) begin
      if (mst_req_o[i] & mst_ack_i[i]) mst_req_o[i] <= 1'b0;
      if ((i == 1) && tkb) begin
        mst_req_o[1] <= 1'b1;
        mst_we_o[1] <= wb_we_i;
        mst_addr_o[63:32] <= wb_adr_i;
        mst_wdata_o[63:32] <= wb_dat_i;
        mst_size_o[3:2] <= `DSD_SZ_WORD;
        bown[1] <= `DSD_OWN_BRG;
      end
      for (s = 0; s < 2; s = s + 1) begin
        if (tk[s] && (rqif[s] == i[1:0]) && !rqchk[s]) begin
          mst_req_o[i] <= 1'b1;
          mst_we_o[i] <= rqwe[s];
          mst_addr_o[i * 32 +: 32] <= rqa[s];
          mst_wdata_o[i * 32 +: 32] <= dat[s] & wmsk(rqsz[s]);
          mst_size_o[i * 2 +: 2] <= rqsz[s];
          bown[i] <= {1'b0, s[0]};
        end
      end
    end
    for (s = 0; s < 2; s = s + 1) begin
      c = s * 8 + cur[s];
      case (st[s])
        S_IDLE: begin
          if (anyr[s]) begin
            cur[s] <= pk[s];
            swp[s * 8 + pk[s]] <= 1'b0;
            hwp[s * 8 + pk[s]] <= 1'b0;
            st[s] <= S_RD;
          end
        end
        S_RD: begin
          if (tk[s]) iss[s] <= 1'b1;
          if (rv[s]) begin
            dat[s] <= rdd[s] & wmsk(rqsz[s]);
            iss[s] <= 1'b0;
            st[s] <= S_WR;
          end
        end
        S_WR: begin
          if (tk[s]) begin
            if (rqchk[s]) chk <= crc(chk, dat[s], rqsz[s]);
            st[s] <= S_UPD;
          end
        end
        S_UPD: begin
          src[c] <= amod(src[c], ctl[c][`DSD_C_SMOD], ctl[c][`DSD_C_WID],
            ctl[c][`DSD_C_CSRC], ctl[c][`DSD_C_CSZ]);
          dst[c] <= amod(dst[c], ctl[c][`DSD_C_DMOD], ctl[c][`DSD_C_WID],
            ctl[c][`DSD_C_CDST], ctl[c][`DSD_C_CSZ]);
          if (cnt[c] == 16'h0001) begin
            ctl[c][`DSD_C_DONE] <= 1'b1;
            if (ctl[c][`DSD_C_IRQEN]) srq_o[c] <= 1'b1;
            if (ctl[c][`DSD_C_CONT]) begin
              cnt[c] <= cini[c];
            end else begin
              cnt[c] <= 16'h0000;
              ctl[c][`DSD_C_EN] <= 1'b0;
            end
          end else if (cnt[c] != 16'h0000) begin
            cnt[c] <= cnt[c] - 16'h0001;
          end
          st[s] <= S_IDLE;
        end
        default: st[s] <= S_IDLE;
      endcase
    end
    // new requests are placed last so they win over the consume above
    for (c = 0; c < 16; c = c + 1) begin
      if (hedge[c]) hwp[c] <= 1'b1;
    end
    if (wb_loc && wb_we_i && !wb_adr_i[`DSD_GLOBAL_BIT] && (wb_adr_i[3:2] == `DSD_R_CTL) &&
      wb_sel_i[3] && wb_dat_i[`DSD_C_SWREQ]) swp[wc] <= 1'b1;
  end
end

endmodule // dsdma_top

`default_nettype wire
